/* File: pdc_bank.sv */
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// R01 - tref reg bit4 turns timing buffer off
// R02 - chan reg bit7 turns channel A off
// R03 - chan reg bit6 turns channel B off
// R04 - chan reg bit3 turns channel D off
// R05 - chan reg bit2 turns channel C off
// R06 - gsync reg bit4 turns sync AB buffer off
// R07 - gsync reg bit0 forces whole-device power-down
// R08 - pin reg bit1 routes pin: fast or global
// R09 - pin reg bit0 forces quick power-down
// R10 - software keeps reserved bits zero
// R11 - all registers and outputs reset to zero, except hready_r and hreadyout, which reset to one
// R12 - synccd reg bit1 turns sync CD off
// R13 - controls are levels, clear restores
module pdc_bank import pdc_pkg::*; #(
  parameter int ADDR_W = PDC_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic powerdown_pin,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic timing_ref_buffer_off,
  output logic channel_a_off,
  output logic channel_b_off,
  output logic channel_c_off,
  output logic channel_d_off,
  output logic sync_pair_ab_buffer_off,
  output logic sync_pair_cd_buffer_off,
  output logic whole_device_off,
  output logic quick_powerdown,
  output logic powerdown_pin_select
);

  // ***************************************************************
  // address decode
  // ***************************************************************
  // used for both the write capture and the read mux
  function automatic pdc_sel_t pdc_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    pdc_decode = PDC_SEL_NONE;
    // unmapped indices keep this default and read as zero
    // misaligned addresses map to nothing
    if (a[1:0] == 2'h0) begin
      if (idx == (ADDR_W-2)'(PDC_IDX_TREF)) pdc_decode = PDC_SEL_TREF;
      else if (idx == (ADDR_W-2)'(PDC_IDX_CHAN)) pdc_decode = PDC_SEL_CHAN;
      else if (idx == (ADDR_W-2)'(PDC_IDX_GSYNC)) pdc_decode = PDC_SEL_GSYNC;
      else if (idx == (ADDR_W-2)'(PDC_IDX_PIN)) pdc_decode = PDC_SEL_PIN;
      else if (idx == (ADDR_W-2)'(PDC_IDX_SYNCCD)) pdc_decode = PDC_SEL_SYNCCD;
    end
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  logic [7:0] tref_r, tref_nxt; // timing reference buffer control
  logic [7:0] chan_r, chan_nxt; // channel power control
  logic [7:0] gsync_r, gsync_nxt; // global and sync AB control
  logic [7:0] pin_r, pin_nxt; // pin mode and quick control
  logic [7:0] synccd_r, synccd_nxt; // sync CD control
  logic wr_pend_r, wr_pend_nxt; // write data phase pending
  pdc_sel_t wr_sel_r, wr_sel_nxt; // target of pending write
  logic [31:0] hrdata_r, hrdata_nxt; // read data
  logic hready_r, hready_nxt; // slave ready
  logic pin_meta_r, pin_meta_nxt; // first sync stage
  logic pin_sync_r, pin_sync_nxt; // second sync stage
  logic [9:0] out_r, out_nxt; // power-down outputs
  logic acc; // address phase taken this cycle
  pdc_sel_t acc_sel; // decoded target of that phase
  logic wr_go; // write commits at this edge
  logic [7:0] rd_val; // read mux result

  // ***************************************************************
  // next state
  // ***************************************************************
  // hsize is not checked: every access is treated as a word
  always_comb begin
    tref_nxt = tref_r;
    chan_nxt = chan_r;
    gsync_nxt = gsync_r;
    pin_nxt = pin_r;
    synccd_nxt = synccd_r;
    wr_pend_nxt = wr_pend_r;
    wr_sel_nxt = wr_sel_r;
    hrdata_nxt = hrdata_r;
    // zero wait states: the slave never stretches a data phase
    hready_nxt = 1'b1;
    pin_meta_nxt = pin_meta_r;
    pin_sync_nxt = pin_sync_r;
    out_nxt = out_r;
    rd_val = 8'h00;
    // a transfer is taken only while the bus is ready
    acc = hsel && hready && (htrans == PDC_HTRANS_NONSEQ);
    acc_sel = pdc_decode(haddr);
    wr_go = ce && wr_pend_r;
    // low ce freezes everything
    if (ce) begin
      // data phase write; reserved bits masked off
      if (wr_pend_r) begin
        case (wr_sel_r)
          PDC_SEL_TREF: tref_nxt = hwdata[7:0] & PDC_MASK_TREF;
          PDC_SEL_CHAN: chan_nxt = hwdata[7:0] & PDC_MASK_CHAN;
          PDC_SEL_GSYNC: gsync_nxt = hwdata[7:0] & PDC_MASK_GSYNC;
          PDC_SEL_PIN: pin_nxt = hwdata[7:0] & PDC_MASK_PIN;
          PDC_SEL_SYNCCD: synccd_nxt = hwdata[7:0] & PDC_MASK_SYNCCD;
          default: ;
        endcase
      end
      // capture the address phase of the next transfer
      wr_pend_nxt = acc && hwrite;
      wr_sel_nxt = acc ? acc_sel : PDC_SEL_NONE;
      // reads look at the next values so a write just before is seen
      case (acc_sel)
        PDC_SEL_TREF: rd_val = tref_nxt;
        PDC_SEL_CHAN: rd_val = chan_nxt;
        PDC_SEL_GSYNC: rd_val = gsync_nxt;
        PDC_SEL_PIN: rd_val = pin_nxt;
        PDC_SEL_SYNCCD: rd_val = synccd_nxt;
        default: rd_val = 8'h00;
      endcase
      if (acc && !hwrite) begin
        hrdata_nxt = {24'h000000, rd_val};
      end
      // pin passes two flops before use
      pin_meta_nxt = powerdown_pin;
      pin_sync_nxt = pin_meta_r;
      // R13 level controls
      // R01 timing buffer off
      out_nxt[0] = tref_nxt[PDC_TREF_BIT];
      // R02 channel A off
      out_nxt[1] = chan_nxt[PDC_CHA_BIT];
      // R03 channel B off
      out_nxt[2] = chan_nxt[PDC_CHB_BIT];
      // R05 channel C off
      out_nxt[3] = chan_nxt[PDC_CHC_BIT];
      // R04 channel D off
      out_nxt[4] = chan_nxt[PDC_CHD_BIT];
      // R06 sync AB off
      out_nxt[5] = gsync_nxt[PDC_SYNCAB_BIT];
      // R12 sync CD off
      out_nxt[6] = synccd_nxt[PDC_SYNCCD_BIT];
      // only the second stage feeds logic; the first may still be metastable
      // R07 R08 pin joins global power-down in global mode
      out_nxt[7] = gsync_nxt[PDC_GLOBAL_BIT]
                   | (pin_sync_r & pin_nxt[PDC_PINSEL_BIT]);
      // R09 R08 pin joins quick power-down in fast mode
      out_nxt[8] = pin_nxt[PDC_FAST_BIT]
                   | (pin_sync_r & ~pin_nxt[PDC_PINSEL_BIT]);
      out_nxt[9] = pin_nxt[PDC_PINSEL_BIT];
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // R11 synchronous clear of the whole bank
  // reset wins over ce so a frozen bank still clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tref_r <= PDC_RST_VAL;
      chan_r <= PDC_RST_VAL;
      gsync_r <= PDC_RST_VAL;
      pin_r <= PDC_RST_VAL;
      synccd_r <= PDC_RST_VAL;
      wr_pend_r <= 1'b0;
      wr_sel_r <= PDC_SEL_NONE;
      hrdata_r <= 32'h00000000;
      hready_r <= 1'b1;
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      out_r <= 10'h000;
    end else begin
      tref_r <= tref_nxt;
      chan_r <= chan_nxt;
      gsync_r <= gsync_nxt;
      pin_r <= pin_nxt;
      synccd_r <= synccd_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_sel_r <= wr_sel_nxt;
      hrdata_r <= hrdata_nxt;
      hready_r <= hready_nxt;
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
      out_r <= out_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign hrdata = hrdata_r;
  assign hreadyout = hready_r;
  assign hresp = PDC_HRESP_OKAY;
  assign timing_ref_buffer_off = out_r[0];
  assign channel_a_off = out_r[1];
  assign channel_b_off = out_r[2];
  assign channel_c_off = out_r[3];
  assign channel_d_off = out_r[4];
  assign sync_pair_ab_buffer_off = out_r[5];
  assign sync_pair_cd_buffer_off = out_r[6];
  assign whole_device_off = out_r[7];
  assign quick_powerdown = out_r[8];
  assign powerdown_pin_select = out_r[9];

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write checks look one edge after the data phase commits

  chk_tref_write: assert property ( // R01
    wr_go && wr_sel_r == PDC_SEL_TREF
    |=> timing_ref_buffer_off == $past(hwdata[PDC_TREF_BIT]))
    else $error("timing buffer control not taken");
  chk_cha_write: assert property ( // R02
    wr_go && wr_sel_r == PDC_SEL_CHAN
    |=> channel_a_off == $past(hwdata[PDC_CHA_BIT]))
    else $error("channel A control not taken");
  chk_chb_write: assert property ( // R03
    wr_go && wr_sel_r == PDC_SEL_CHAN
    |=> channel_b_off == $past(hwdata[PDC_CHB_BIT]))
    else $error("channel B control not taken");
  chk_chd_write: assert property ( // R04
    wr_go && wr_sel_r == PDC_SEL_CHAN
    |=> channel_d_off == $past(hwdata[PDC_CHD_BIT]))
    else $error("channel D control not taken");
  chk_chc_write: assert property ( // R05
    wr_go && wr_sel_r == PDC_SEL_CHAN
    |=> channel_c_off == $past(hwdata[PDC_CHC_BIT]))
    else $error("channel C control not taken");
  chk_syncab_write: assert property ( // R06
    wr_go && wr_sel_r == PDC_SEL_GSYNC
    |=> sync_pair_ab_buffer_off == $past(hwdata[PDC_SYNCAB_BIT]))
    else $error("sync AB control not taken");
  chk_global_force: assert property ( // R07
    wr_go && wr_sel_r == PDC_SEL_GSYNC && hwdata[PDC_GLOBAL_BIT]
    |=> whole_device_off)
    else $error("global power-down not forced");
  // pin checks start at the second sync stage and look after the output flop
  chk_pin_fast: assert property ( // R08
    ce && pin_sync_r && !pin_nxt[PDC_PINSEL_BIT]
    |=> quick_powerdown)
    else $error("pin did not give quick power-down");
  chk_pin_global: assert property ( // R08
    ce && pin_sync_r && pin_nxt[PDC_PINSEL_BIT]
    |=> whole_device_off
    && (quick_powerdown == $past(pin_nxt[PDC_FAST_BIT])))
    else $error("pin mode not honoured");
  chk_quick_force: assert property ( // R09
    wr_go && wr_sel_r == PDC_SEL_PIN && hwdata[PDC_FAST_BIT]
    |=> quick_powerdown)
    else $error("quick power-down not forced");
  chk_reset_zero: assert property ( // R11
    $rose(rst_n) |-> out_r == 10'h000 && hrdata == 32'h00000000)
    else $error("outputs not zero after reset");
  chk_synccd_write: assert property ( // R12
    wr_go && wr_sel_r == PDC_SEL_SYNCCD
    |=> sync_pair_cd_buffer_off == $past(hwdata[PDC_SYNCCD_BIT]))
    else $error("sync CD control not taken");
  chk_level_hold: assert property ( // R13
    !(wr_go && wr_sel_r == PDC_SEL_CHAN) |=> $stable(channel_a_off))
    else $error("channel A control moved without a write");
  chk_resv_read: assert property ( // R10
    hrdata[31:8] == 24'h000000 && (chan_r & ~PDC_MASK_CHAN) == 8'h00
    && (tref_r & ~PDC_MASK_TREF) == 8'h00 && (gsync_r & ~PDC_MASK_GSYNC) == 8'h00
    && (pin_r & ~PDC_MASK_PIN) == 8'h00 && (synccd_r & ~PDC_MASK_SYNCCD) == 8'h00)
    else $error("reserved bits not zero");
  chk_global_idle: assert property ( // R07
    wr_go && wr_sel_r == PDC_SEL_GSYNC && !hwdata[PDC_GLOBAL_BIT] && !pin_sync_r
    |=> !whole_device_off)
    else $error("global power-down without cause");
  chk_quick_idle: assert property ( // R09
    wr_go && wr_sel_r == PDC_SEL_PIN && !hwdata[PDC_FAST_BIT] && !pin_sync_r
    |=> !quick_powerdown)
    else $error("quick power-down without cause");
  chk_pinsel_write: assert property ( // R08
    wr_go && wr_sel_r == PDC_SEL_PIN
    |=> powerdown_pin_select == $past(hwdata[PDC_PINSEL_BIT]))
    else $error("pin mode select not taken");
  chk_freeze_hold: assert property ( // R13
    !ce |=> $stable(out_r) && $stable(hrdata))
    else $error("state moved while ce was low");

  // main scenarios reached by the bench
  cov_chan_write: cover property (wr_go && wr_sel_r == PDC_SEL_CHAN);
  cov_ce_freeze: cover property (!ce ##1 ce);
  cov_pin_fast: cover property (pin_sync_r && !pin_r[PDC_PINSEL_BIT]);
  cov_pin_global: cover property (pin_sync_r && pin_r[PDC_PINSEL_BIT]);
  cov_read_back: cover property (acc && !hwrite && ce ##1 hrdata != 32'h0);

endmodule

/* File: pdc_bank_tb_top.sv */
`timescale 1ns/10ps
module pdc_bank_tb_top import pdc_pkg::*;;
  // ***************************************************************
  // stimulus and observed signals
  // ***************************************************************
  logic clk;
  logic rst_n;
  logic ce;
  logic hsel;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic powerdown_pin;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [9:0] outs; // every power-down output, field table order
  int bad_count;
  int checked;
  logic [31:0] rd;
  // field table: register index and bit of each output in outs order
  logic [7:0] f_idx [10] = '{PDC_IDX_TREF, PDC_IDX_CHAN, PDC_IDX_CHAN, PDC_IDX_CHAN,
    PDC_IDX_CHAN, PDC_IDX_GSYNC, PDC_IDX_SYNCCD, PDC_IDX_GSYNC, PDC_IDX_PIN, PDC_IDX_PIN};
  int f_bit [10] = '{PDC_TREF_BIT, PDC_CHA_BIT, PDC_CHB_BIT, PDC_CHC_BIT, PDC_CHD_BIT,
    PDC_SYNCAB_BIT, PDC_SYNCCD_BIT, PDC_GLOBAL_BIT, PDC_FAST_BIT, PDC_PINSEL_BIT};
  logic [7:0] r_idx [5] = '{PDC_IDX_TREF, PDC_IDX_CHAN, PDC_IDX_GSYNC, PDC_IDX_PIN,
    PDC_IDX_SYNCCD};
  logic [7:0] r_mask [5] = '{PDC_MASK_TREF, PDC_MASK_CHAN, PDC_MASK_GSYNC, PDC_MASK_PIN,
    PDC_MASK_SYNCCD};
  // ce is driven so that the freeze of the bank is exercised too
  pdc_bank #(.ADDR_W(12)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .powerdown_pin(powerdown_pin), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .timing_ref_buffer_off(outs[9]), .channel_a_off(outs[8]), .channel_b_off(outs[7]),
    .channel_c_off(outs[6]), .channel_d_off(outs[5]), .sync_pair_ab_buffer_off(outs[4]),
    .sync_pair_cd_buffer_off(outs[3]), .whole_device_off(outs[2]),
    .quick_powerdown(outs[1]), .powerdown_pin_select(outs[0]));
  // ***************************************************************
  // clock and watchdog
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    bad_count++;
    wrap_up();
  end
  // ***************************************************************
  // bus tasks and compare
  // ***************************************************************
  // one single word transfer; waits for hready at both phases
  task automatic bus_xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rdat);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PDC_HTRANS_NONSEQ;
    hsize <= 3'h2;
    // no cycle count is assumed: only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    rdat = hrdata;
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus_xfer({2'h0, idx, 2'h0}, 1'b1, {24'h0, d}, rd);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    bus_xfer(a, 1'b0, 32'h0, rd);
    chk("read data", {24'h0, exp}, rd);
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    powerdown_pin = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    #1;
    chk("outputs in reset", 32'h0, {22'h0, outs});
    chk("ready in reset", 32'h1, {31'h0, hreadyout});
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, then every writable bit set with reserved bits kept zero
    for (int r = 0; r < 5; r++) begin
      rd_chk({2'h0, r_idx[r], 2'h0}, 8'h00);
      wr(r_idx[r], r_mask[r]);
      rd_chk({2'h0, r_idx[r], 2'h0}, r_mask[r]);
      wr(r_idx[r], 8'h00);
    end
    // each field alone drives exactly its output, clearing restores
    for (int i = 0; i < 10; i++) begin
      wr(f_idx[i], 8'h01 << f_bit[i]);
      chk("field output set", 32'h200 >> i, {22'h0, outs});
      repeat (3) @(posedge clk);
      #1;
      chk("field output held", 32'h200 >> i, {22'h0, outs});
      wr(f_idx[i], 8'h00);
      chk("field output cleared", 32'h0, {22'h0, outs});
    end
    // an unmapped place ignores a write; unmapped and misaligned places read zero
    bus_xfer(12'h270, 1'b1, 32'h000000FF, rd);
    rd_chk(12'h270, 8'h00);
    rd_chk(12'h275, 8'h00);
    chk("outputs after unmapped write", 32'h0, {22'h0, outs});
    // pin in fast mode, then in global mode
    for (int m = 0; m < 2; m++) begin
      wr(PDC_IDX_PIN, m[0] ? 8'h02 : 8'h00);
      powerdown_pin <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("pin routed", m[0] ? 32'h5 : 32'h2, {22'h0, outs});
      powerdown_pin <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("pin released", {31'h0, m[0]}, {22'h0, outs});
    end
    // with ce low the bank is frozen, so a pin change waits for ce
    ce <= 1'b0;
    powerdown_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("frozen by ce", 32'h1, {22'h0, outs});
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pin after ce", 32'h5, {22'h0, outs});
    powerdown_pin <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("pin after ce released", 32'h1, {22'h0, outs});
    // second reset with every field set
    for (int r = 0; r < 5; r++) wr(r_idx[r], r_mask[r]);
    chk("all fields set", 32'h3FF, {22'h0, outs});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("outputs after reset", 32'h0, {22'h0, outs});
    for (int r = 0; r < 5; r++) rd_chk({2'h0, r_idx[r], 2'h0}, 8'h00);
    wrap_up();
  end
endmodule

/* File: pdc_pkg.sv */
// ***************************************************************
// power-down control bank constants
// ***************************************************************
package pdc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] PDC_IDX_TREF = 8'h9B;
  localparam logic [7:0] PDC_IDX_CHAN = 8'h9D;
  localparam logic [7:0] PDC_IDX_GSYNC = 8'h9E;
  localparam logic [7:0] PDC_IDX_PIN = 8'h9F;
  localparam logic [7:0] PDC_IDX_SYNCCD = 8'hAF;
  // default byte address width of the bus slave
  localparam int PDC_ADDR_W = 12;
  // field positions
  localparam int PDC_TREF_BIT = 4;
  localparam int PDC_CHA_BIT = 7;
  localparam int PDC_CHB_BIT = 6;
  localparam int PDC_CHD_BIT = 3;
  localparam int PDC_CHC_BIT = 2;
  localparam int PDC_SYNCAB_BIT = 4;
  localparam int PDC_GLOBAL_BIT = 0;
  localparam int PDC_PINSEL_BIT = 1;
  localparam int PDC_FAST_BIT = 0;
  localparam int PDC_SYNCCD_BIT = 1;
  // writable bits; reserved bits are never stored
  localparam logic [7:0] PDC_MASK_TREF = 8'h10;
  localparam logic [7:0] PDC_MASK_CHAN = 8'hCC;
  localparam logic [7:0] PDC_MASK_GSYNC = 8'h11;
  localparam logic [7:0] PDC_MASK_PIN = 8'h03;
  localparam logic [7:0] PDC_MASK_SYNCCD = 8'h02;
  // reset value of every register
  localparam logic [7:0] PDC_RST_VAL = 8'h00;
  // bus encodings
  localparam logic [1:0] PDC_HTRANS_NONSEQ = 2'h2;
  localparam logic PDC_HRESP_OKAY = 1'h0;
  // register selector
  typedef enum logic [2:0] {
    PDC_SEL_NONE, PDC_SEL_TREF, PDC_SEL_CHAN, PDC_SEL_GSYNC,
    PDC_SEL_PIN, PDC_SEL_SYNCCD
  } pdc_sel_t;
endpackage
